// ### rtl/dsr_pkg.sv
// Purpose: Constants for the dual 8-bit shift register block
// Assumes: One 20 MHz system clock, synchronous active-low reset
// Notes:   Shift and load act on rising edges of their lines; clear is a level sampled per clock
package dsr_pkg;

  // ---------------------------------------------------------------
  // Geometry and reset values
  // ---------------------------------------------------------------
  localparam int unsigned DSR_STAGES    = 8;
  localparam int unsigned DSR_REGS      = 2;
  localparam logic [7:0]  DSR_RST_VALUE = 8'h00;

  // ---------------------------------------------------------------
  // Load enable setup time before the load strobe
  // ---------------------------------------------------------------
  localparam int unsigned DSR_CLK_PERIOD_NS  = 50;
  localparam int unsigned DSR_LOAD_SETUP_NS  = 400;
  localparam int unsigned DSR_LOAD_SETUP_CYC =
    (DSR_LOAD_SETUP_NS + DSR_CLK_PERIOD_NS - 1) / DSR_CLK_PERIOD_NS;

  // Strobe edge detector states
  typedef enum logic [0:0] {
    DSR_IDLE = 1'b0,
    DSR_HIGH = 1'b1
  } dsr_strobe_e;

endpackage

// ### rtl/dsr_stage_chain.sv
// Purpose: One eight-stage shift register with clear and parallel set
// Assumes: Strobes are single-cycle pulses from the top level
// Notes:   Clear has priority over load, load over shift
`timescale 1ns/100ps
`default_nettype none
module dsr_stage_chain
  import dsr_pkg::*;
#(
  parameter int unsigned STAGES = DSR_STAGES
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              shift_pulse,
  input  wire logic              clear,
  input  wire logic              load_pulse,
  input  wire logic [STAGES-1:0] load_ok,
  input  wire logic              first_in,
  output logic      [STAGES-1:0] stages_q
);

  logic [STAGES-1:0] stages_d;

  // ---------------------------------------------------------------
  // Next stage values
  // ---------------------------------------------------------------
  always_comb begin
    stages_d = stages_q;
    if (clear) begin
      stages_d = '0;
    end else if (load_pulse) begin
      stages_d = stages_q | load_ok;
    end else if (shift_pulse) begin
      stages_d = {stages_q[STAGES-2:0], first_in};
    end
  end

  // Stage flip-flops
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stages_q <= '0;
    end else begin
      stages_q <= stages_d;
    end
  end

endmodule
`default_nettype wire

// ### rtl/dsr_dual_shift.sv
// Purpose: Dual 8-bit shift register with common shift, clear and load
// Assumes: All inputs synchronous to clock; enables active low
// Notes:   Loads a one only where enable stayed low for the setup time
`timescale 1ns/100ps
`default_nettype none
module dsr_dual_shift
  import dsr_pkg::*;
#(
  parameter int unsigned STAGES = DSR_STAGES
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              shift_line,
  input  wire logic              clear_line,
  input  wire logic              load_strobe,
  input  wire logic [STAGES-1:0] load_en_a_n,
  input  wire logic [STAGES-1:0] load_en_b_n,
  input  wire logic              first_in_a,
  input  wire logic              first_in_b,
  output logic      [STAGES-1:0] reg_a_q,
  output logic      [STAGES-1:0] reg_b_q
);

  localparam int unsigned CW = $clog2(DSR_LOAD_SETUP_CYC + 1);
  localparam logic [CW-1:0] SETUP_MAX = CW'(DSR_LOAD_SETUP_CYC);

  // ---------------------------------------------------------------
  // Edge detection on shift and load lines
  // ---------------------------------------------------------------
  dsr_strobe_e shift_st_q, shift_st_d, load_st_q, load_st_d;
  logic        shift_pulse, load_pulse;

  always_comb begin
    shift_st_d = shift_line ? DSR_HIGH : DSR_IDLE;
    load_st_d  = load_strobe ? DSR_HIGH : DSR_IDLE;
    shift_pulse = shift_line && (shift_st_q == DSR_IDLE);
    load_pulse  = load_strobe && (load_st_q == DSR_IDLE);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_st_q <= DSR_IDLE;
      load_st_q  <= DSR_IDLE;
    end else begin
      shift_st_q <= shift_st_d;
      load_st_q  <= load_st_d;
    end
  end

  // ---------------------------------------------------------------
  // Setup counters: enable must be low long enough before strobe
  // ---------------------------------------------------------------
  logic [CW-1:0]     cnt_a_q [STAGES];
  logic [CW-1:0]     cnt_a_d [STAGES];
  logic [CW-1:0]     cnt_b_q [STAGES];
  logic [CW-1:0]     cnt_b_d [STAGES];
  logic [STAGES-1:0] ok_a, ok_b;

  function automatic logic [CW-1:0] setup_next(input logic en_n,
                                               input logic [CW-1:0] c);
    if (en_n) begin
      setup_next = '0;
    end else if (c != SETUP_MAX) begin
      setup_next = c + CW'(1);
    end else begin
      setup_next = c;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : g_setup
      always_comb begin
        cnt_a_d[g] = setup_next(load_en_a_n[g], cnt_a_q[g]);
        cnt_b_d[g] = setup_next(load_en_b_n[g], cnt_b_q[g]);
        ok_a[g] = !load_en_a_n[g] && (cnt_a_q[g] == SETUP_MAX);
        ok_b[g] = !load_en_b_n[g] && (cnt_b_q[g] == SETUP_MAX);
      end

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          cnt_a_q[g] <= '0;
          cnt_b_q[g] <= '0;
        end else begin
          cnt_a_q[g] <= cnt_a_d[g];
          cnt_b_q[g] <= cnt_b_d[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Two independent chains; first inputs come from pins
  // ---------------------------------------------------------------
  dsr_stage_chain #(.STAGES(STAGES)) u_reg_a (
    .clock       (clock),
    .rst_n       (rst_n),
    .shift_pulse (shift_pulse),
    .clear       (clear_line),
    .load_pulse  (load_pulse),
    .load_ok     (ok_a),
    .first_in    (first_in_a),
    .stages_q    (reg_a_q)
  );

  dsr_stage_chain #(.STAGES(STAGES)) u_reg_b (
    .clock       (clock),
    .rst_n       (rst_n),
    .shift_pulse (shift_pulse),
    .clear       (clear_line),
    .load_pulse  (load_pulse),
    .load_ok     (ok_b),
    .first_in    (first_in_b),        // Tie to reg_a_q[7] to cascade
    .stages_q    (reg_b_q)
  );

endmodule
`default_nettype wire

// ### sim/dsr_far_wiring.sv
// Purpose: Far-side wiring of first-stage inputs
// Assumes: Mode 0 open, 1 ring, 2 switch-tail, 3 cascade
// Notes:   Pure wiring, no state
`timescale 1ns/100ps
`default_nettype none
module dsr_far_wiring (
  input  wire logic [1:0] mode,
  input  wire logic       ser_in,
  input  wire logic       last_a,
  input  wire logic       last_b,
  output logic            first_in_a,
  output logic            first_in_b
);
  // Feedback pick per mode
  assign first_in_a = mode == 2'h1 ? last_a :
                      mode == 2'h2 ? ~last_a : ser_in;
  assign first_in_b = mode == 2'h3 ? last_a :
                      mode == 2'h1 ? last_b : mode == 2'h2 ? ~last_b : ser_in;
endmodule
`default_nettype wire

// ### sim/dsr_dual_monitor.sv
// Purpose: Port assertions for the dual shift register
// Assumes: Lines low as reset lifts
// Notes:   Bound at file foot
`timescale 1ns/100ps
`default_nettype none
module dsr_dual_monitor #(parameter int unsigned STAGES = 8) (
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              shift_line,
  input wire logic              clear_line,
  input wire logic              load_strobe,
  input wire logic [STAGES-1:0] load_en_a_n,
  input wire logic              first_in_a,
  input wire logic              first_in_b,
  input wire logic [STAGES-1:0] reg_a_q,
  input wire logic [STAGES-1:0] reg_b_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Shift accepted at this edge
  sequence sh_s; $rose(shift_line) && !clear_line && !$rose(load_strobe);
  endsequence
  shift_a_a: assert property (sh_s |=>
    reg_a_q[STAGES-1:1] == $past(reg_a_q[STAGES-2:0])) else $error("a shift");
  entry_a_a: assert property (sh_s |=>
    reg_a_q[0] == $past(first_in_a)) else $error("a entry");
  shift_b_a: assert property (sh_s |=>
    reg_b_q == {$past(reg_b_q[STAGES-2:0]), $past(first_in_b)})
    else $error("b shift");
  chain_link_a: assert property (
    sh_s and first_in_b == reg_a_q[STAGES-1] |=>
    reg_b_q[0] == $past(reg_a_q[STAGES-1])) else $error("chain");
  clear_all_a: assert property (clear_line |=>
    reg_a_q == '0 && reg_b_q == '0) else $error("clear");
  load_or_a: assert property ($rose(load_strobe) && !clear_line |=>
    reg_a_q == ($past(reg_a_q) | (reg_a_q & ~$past(load_en_a_n))))
    else $error("load");
  hold_idle_a: assert property (
    !$rose(shift_line) && !clear_line && !$rose(load_strobe) |=>
    $stable(reg_a_q) && $stable(reg_b_q)) else $error("hold");
endmodule
bind dsr_dual_shift dsr_dual_monitor #(.STAGES(STAGES)) u_mon (.clock(clock),
  .rst_n(rst_n), .shift_line(shift_line), .clear_line(clear_line),
  .load_strobe(load_strobe), .load_en_a_n(load_en_a_n), .reg_b_q(reg_b_q),
  .first_in_a(first_in_a), .first_in_b(first_in_b), .reg_a_q(reg_a_q));
`default_nettype wire

// ### sim/dsr_dual_shift_tb.sv
// Purpose: Self-checking bench for the dual shift register
// Assumes: Far-side model sets feedback mode
// Notes:   Rows clear, load, shift, compare
`timescale 1ns/100ps
`default_nettype none
module dsr_dual_shift_tb;
  typedef struct {logic [1:0] m; logic s; logic [7:0] la, lb, ea, eb; int n;}
    dsr_row_s;
  logic clock, rst_n, shift_line, clear_line, load_strobe, ser_in, fi_a, fi_b;
  logic [1:0] mode;
  logic [7:0] en_a_n, en_b_n, reg_a_q, reg_b_q;
  int fail_count, checked;
  dsr_row_s rows [5] = '{'{2'h0, 1'h1, 8'h00, 8'h00, 8'h07, 8'h07, 3},
    '{2'h1, 1'h0, 8'h81, 8'h01, 8'h03, 8'h02, 1},
    '{2'h2, 1'h0, 8'h00, 8'h00, 8'hff, 8'hff, 8},
    '{2'h3, 1'h0, 8'h80, 8'h00, 8'h00, 8'h01, 1},
    '{2'h0, 1'h0, 8'ha5, 8'h3c, 8'ha5, 8'h3c, 0}};
  dsr_dual_shift u_dsr_dual_shift (.clock(clock), .rst_n(rst_n),
    .shift_line(shift_line), .clear_line(clear_line), .reg_b_q(reg_b_q),
    .load_strobe(load_strobe), .load_en_a_n(en_a_n), .load_en_b_n(en_b_n),
    .first_in_a(fi_a), .first_in_b(fi_b), .reg_a_q(reg_a_q));
  dsr_far_wiring u_dsr_far_wiring (.mode(mode), .ser_in(ser_in),
    .last_a(reg_a_q[7]), .last_b(reg_b_q[7]), .first_in_a(fi_a),
    .first_in_b(fi_b));
  // Compare one stage vector
  task automatic chk(input string what, input logic [7:0] exp, got);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  // Enables low for hold edges, then one strobe
  task automatic load(input logic [7:0] pa, pb, input int hold);
    en_a_n <= ~pa;
    en_b_n <= ~pb;
    repeat (hold) @(posedge clock);
    load_strobe <= 1'b1;
    @(posedge clock);
    load_strobe <= 1'b0;
    en_a_n <= 8'hff;
    en_b_n <= 8'hff;
    @(posedge clock);
  endtask
  // One clear or shift pulse
  task automatic pulse(input logic clr);
    if (clr) clear_line <= 1'b1;
    else shift_line <= 1'b1;
    @(posedge clock);
    clear_line <= 1'b0;
    shift_line <= 1'b0;
    @(posedge clock);
  endtask
  task automatic close_out();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Main sequence
  initial begin
    {rst_n, shift_line, clear_line, load_strobe, ser_in, mode} = '0;
    {en_a_n, en_b_n} = 16'hffff;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      mode <= rows[i].m;
      ser_in <= rows[i].s;
      pulse(1'b1);
      load(rows[i].la, rows[i].lb, 9);
      repeat (rows[i].n) pulse(1'b0);
      chk("row a", rows[i].ea, reg_a_q);
      chk("row b", rows[i].eb, reg_b_q);
    end
    load(8'h02, 8'h00, 3);
    chk("short load", 8'ha5, reg_a_q);
    pulse(1'b1);
    chk("clear", 8'h00, reg_a_q);
    chk("clear b", 8'h00, reg_b_q);
    load(8'hff, 8'hff, 9);
    chk("full a", 8'hff, reg_a_q);
    chk("full b", 8'hff, reg_b_q);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("reset", 8'h00, reg_b_q);
    chk("reset a", 8'h00, reg_a_q);
    close_out();
  end
endmodule
`default_nettype wire
